// ### esc_dev.sv
// Decided for this implementation: the register addresses and the APB slave port.
`timescale 1ns/100ps
// How it works
// RULE_01: System coprocessor op unusable outside kernel/debug. The code still lets it through there while sys_coproc_usable is set.
// RULE_02: Floating-point ops unusable when its bit clear.
// RULE_03: Coprocessor-2 ops unusable when its bit clear.
// RULE_04: Record referenced coprocessor unit number.
// RULE_05: Media-extension op unusable when its bit clear.
// RULE_06: Floating-point unit request causes floating-point exception.
// RULE_07: Coprocessor 2 request causes precise exception.
// RULE_08: These classes use general vector 0x180.
// RULE_09: Interrupt uses 0x200 when vector select set.
// RULE_10: Watch match taken at once outside exception levels.
// RULE_11: Otherwise set watch-pending and defer.
// RULE_12: Deferred watch lets lower-priority exception through.
// RULE_13: Debug mode suppresses watch, pending bit kept.
// RULE_14: Store-conditional watch fires regardless of link flag.
// RULE_15: Pending watch fires until software clears it.
// RULE_16: Enabled pending interrupt causes interrupt exception.
// RULE_17: One to sixteen sets, highest reported.
// RULE_18: Normal access uses current set, previous-set instructions previous.
// RULE_19: Skip set update for special entries or levels.
// RULE_20: Entry copies current set to previous.
// RULE_21: New set from map, controller or exception field.
// RULE_22: Return restores previous set unless excluded.
// RULE_23: Write class exception code on entry.
module esc_dev
   import esc_pkg::*;
#(
   parameter int NUM_SETS = ESC_NUM_SETS,
   parameter logic [4:0] CODE_INT = ESC_DEF_CODE_INT,
   parameter logic [4:0] CODE_CPU = ESC_DEF_CODE_CPU,
   parameter logic [4:0] CODE_MEDIA = ESC_DEF_CODE_MEDIA,
   parameter logic [4:0] CODE_FP = ESC_DEF_CODE_FP,
   parameter logic [4:0] CODE_CP2 = ESC_DEF_CODE_CP2,
   parameter logic [4:0] CODE_WATCH = ESC_DEF_CODE_WATCH
) (
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // Instruction at the exception stage
   input wire logic instr_valid,
   input wire esc_iclass_t instr_class,
   input wire logic read_prev_set_instr,
   input wire logic write_prev_set_instr,
   input wire logic watch_match,
   input wire logic lower_exc_req,
   input wire logic [4:0] lower_exc_code,
   // Processor mode and status bits
   input wire logic debug_mode,
   input wire logic kernel_mode,
   input wire logic sys_coproc_usable,
   input wire logic fp_coproc_usable,
   input wire logic coproc2_usable,
   input wire logic media_ext_usable,
   input wire logic exception_level_bit,
   input wire logic error_level_bit,
   input wire logic bootstrap_vector_bit,
   input wire logic int_enable,
   input wire logic [7:0] int_mask,
   // Configuration
   input wire logic interrupt_vector_select,
   input wire logic external_int_ctrl_present,
   input wire logic vectored_int_supported,
   // Entries and returns handled elsewhere
   input wire logic special_entry,
   input wire logic exception_return_instr,
   input wire logic debug_return_instr,
   // Software writes
   input wire logic wp_clear,
   input wire logic srs_wr,
   input wire logic [3:0] srs_wr_ess,
   input wire logic [3:0] srs_wr_pss,
   input wire logic map_wr,
   input wire logic [31:0] map_wr_data,
   // Exception outputs
   output logic exc_taken,
   output logic [4:0] exc_code,
   output logic [11:0] exc_vec_offset,
   output logic [1:0] coproc_error_unit,
   output logic watch_pending,
   output logic [7:0] pending_interrupt_field,
   // Shadow set outputs
   output logic [3:0] current_set_number,
   output logic [3:0] previous_set_number,
   output logic [3:0] exception_set_number,
   output logic [3:0] highest_set_number,
   output logic [3:0] gpr_access_set,
   output logic [31:0] shadow_set_map,
   // Coprocessor and controller link
   esc_link_if.dev link
);
   localparam logic [3:0] HIGHEST_SET_NUMBER = 4'(NUM_SETS - 1);

   // Set numbers above the top implemented set fold onto it so no missing set is named.
   function automatic logic [3:0] clamp_set(input logic [3:0] s);
      clamp_set = (s > HIGHEST_SET_NUMBER) ? HIGHEST_SET_NUMBER : s;
   endfunction

   // Highest pending enabled line; the full priority scheme lives outside.
   function automatic logic [2:0] top_line(input logic [7:0] v);
      top_line = 3'h0;
      for (int i = 0; i < ESC_NUM_INT; i++) begin
         if (v[i]) top_line = 3'(i);
      end
   endfunction

   logic taken_r, taken_nxt;
   logic [4:0] code_r, code_nxt;
   logic [11:0] vec_r, vec_nxt;
   logic [1:0] ce_r, ce_nxt;
   logic wp_r, wp_nxt;
   logic [7:0] ip_r, ip_nxt;
   logic [3:0] css_r, css_nxt, pss_r, pss_nxt, ess_r, ess_nxt;
   logic [31:0] map_r, map_nxt;
   logic levels, watch_hit, watch_now, int_now, cpu_now, media_now, fp_now, cp2_now;
   logic [7:0] int_live;
   logic [1:0] cpu_unit;
   logic is_int;
   logic [3:0] new_set;

   assign levels = exception_level_bit | error_level_bit;
   assign int_live = link.int_pending & int_mask;
   // Store-conditional references reach watch_match with no load-linked gating.
   assign watch_hit = watch_match & ~debug_mode; // RULE_13 RULE_14
   assign watch_now = (watch_hit | wp_r) & ~levels & ~debug_mode; // RULE_10 RULE_15
   assign int_now = (|int_live) & int_enable & ~levels & ~debug_mode; // RULE_16
   assign fp_now = link.fp_exc_req & ~debug_mode; // RULE_06
   assign cp2_now = link.cp2_exc_req & ~debug_mode; // RULE_07
   assign media_now = instr_valid & (instr_class == ESC_IC_MEDIA) & ~media_ext_usable; // RULE_05

   always_comb begin
      cpu_now = 1'b0;
      cpu_unit = ESC_UNIT_SYS;
      if (instr_valid) begin
         case (instr_class)
            ESC_IC_SYS: begin
               cpu_now = ~debug_mode & ~kernel_mode & ~sys_coproc_usable; // RULE_01
               cpu_unit = ESC_UNIT_SYS;
            end
            ESC_IC_FP: begin
               cpu_now = ~fp_coproc_usable; // RULE_02
               cpu_unit = ESC_UNIT_FP;
            end
            ESC_IC_CP2: begin
               cpu_now = ~coproc2_usable; // RULE_03
               cpu_unit = ESC_UNIT_CP2;
            end
            default: begin
               cpu_now = 1'b0;
               cpu_unit = ESC_UNIT_SYS;
            end
         endcase
      end
   end

   always_comb begin
      taken_nxt = 1'b0;
      code_nxt = code_r;
      vec_nxt = vec_r;
      ce_nxt = ce_r;
      is_int = 1'b0;
      wp_nxt = wp_r;
      ip_nxt = link.int_pending; // RULE_16
      css_nxt = css_r;
      pss_nxt = pss_r;
      ess_nxt = ess_r;
      map_nxt = map_r;
      link.fp_exc_ack = 1'b0;
      link.cp2_exc_ack = 1'b0;
      if (wp_clear) wp_nxt = 1'b0;
      // A match deferred by the levels sets the bit even while it is being cleared.
      if (watch_hit && levels) wp_nxt = 1'b1; // RULE_11
      if (!special_entry) begin
         taken_nxt = int_now | watch_now | cpu_now | media_now | fp_now | cp2_now | lower_exc_req;
         vec_nxt = ESC_VEC_GENERAL; // RULE_08
         if (int_now) begin
            is_int = 1'b1;
            code_nxt = CODE_INT; // RULE_23
            vec_nxt = interrupt_vector_select ? ESC_VEC_INTERRUPT : ESC_VEC_GENERAL; // RULE_09
         end else if (watch_now) begin
            code_nxt = CODE_WATCH; // RULE_23
         end else if (cpu_now) begin
            code_nxt = CODE_CPU; // RULE_23
            ce_nxt = cpu_unit; // RULE_04
         end else if (media_now) begin
            code_nxt = CODE_MEDIA; // RULE_23
         end else if (fp_now) begin
            code_nxt = CODE_FP; // RULE_23
            link.fp_exc_ack = 1'b1;
         end else if (cp2_now) begin
            code_nxt = CODE_CP2; // RULE_23
            link.cp2_exc_ack = 1'b1;
         end else if (lower_exc_req) begin
            code_nxt = lower_exc_code; // RULE_12
         end
      end
      if (interrupt_vector_select && external_int_ctrl_present) begin
         new_set = link.controller_supplied_set; // RULE_21
      end else if (interrupt_vector_select && vectored_int_supported) begin
         new_set = map_r[top_line(int_live)*ESC_SET_W +: ESC_SET_W]; // RULE_21
      end else begin
         new_set = ess_r;
      end
      if (srs_wr) begin
         ess_nxt = clamp_set(srs_wr_ess); // RULE_17
         pss_nxt = clamp_set(srs_wr_pss);
      end
      if (map_wr) map_nxt = map_wr_data;
      // Nested or early entries keep the set control intact.
      if (taken_nxt && !bootstrap_vector_bit && !exception_level_bit) begin // RULE_19
         pss_nxt = css_r; // RULE_20
         css_nxt = clamp_set(is_int ? new_set : ess_r); // RULE_21
      end else if (exception_return_instr && !debug_return_instr && !error_level_bit
                   && !bootstrap_vector_bit) begin
         css_nxt = pss_r; // RULE_22
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         taken_r <= 1'b0;
         code_r <= 5'h00;
         vec_r <= ESC_VEC_GENERAL;
         ce_r <= 2'h0;
         wp_r <= 1'b0;
         ip_r <= 8'h00;
         css_r <= 4'h0;
         pss_r <= 4'h0;
         ess_r <= 4'h0;
         map_r <= 32'h0;
      end else begin
         taken_r <= taken_nxt;
         code_r <= code_nxt;
         vec_r <= vec_nxt;
         ce_r <= ce_nxt;
         wp_r <= wp_nxt;
         ip_r <= ip_nxt;
         css_r <= css_nxt;
         pss_r <= pss_nxt;
         ess_r <= ess_nxt;
         map_r <= map_nxt;
      end
   end

   assign exc_taken = taken_r;
   assign exc_code = code_r;
   assign exc_vec_offset = vec_r;
   assign coproc_error_unit = ce_r;
   assign watch_pending = wp_r;
   assign pending_interrupt_field = ip_r;
   assign current_set_number = css_r;
   assign previous_set_number = pss_r;
   assign exception_set_number = ess_r;
   assign highest_set_number = HIGHEST_SET_NUMBER; // RULE_17
   assign shadow_set_map = map_r;
   // Ordinary references use the current set; the previous-set instructions reach back.
   assign gpr_access_set = (read_prev_set_instr | write_prev_set_instr) ? pss_r : css_r; // RULE_18
endmodule

// ### esc_far.sv
`timescale 1ns/100ps
module esc_far
   import esc_pkg::*;
(
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // APB slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Link to the exception unit
   esc_link_if.far link
);
   logic fp_req_r, fp_req_nxt, cp2_req_r, cp2_req_nxt;
   logic [ESC_FP_CONTROL_STATUS_REG_W-1:0] fp_control_status_reg_r, fp_control_status_reg_nxt;
   logic [7:0] pend_r, pend_nxt;
   logic [5:0] ipl_r, ipl_nxt;
   logic [3:0] set_r, set_nxt;
   logic [7:0] fp_cnt_r, fp_cnt_nxt, cp2_cnt_r, cp2_cnt_nxt;
   logic [31:0] rdata_r, rdata_nxt;
   logic access, wr, mapped;

   assign pready = 1'b1;
   assign access = psel & penable;
   assign wr = access & pwrite;
   assign mapped = (paddr == ESC_OFF_CTRL) | (paddr == ESC_OFF_FP_CONTROL_STATUS_REG) | (paddr == ESC_OFF_INT)
                   | (paddr == ESC_OFF_STATUS);
   assign pslverr = access & ~mapped;
   assign prdata = rdata_r;

   always_comb begin
      fp_req_nxt = fp_req_r;
      cp2_req_nxt = cp2_req_r;
      fp_control_status_reg_nxt = fp_control_status_reg_r;
      pend_nxt = pend_r;
      ipl_nxt = ipl_r;
      set_nxt = set_r;
      fp_cnt_nxt = fp_cnt_r;
      cp2_cnt_nxt = cp2_cnt_r;
      rdata_nxt = rdata_r;
      // An acknowledge drops a request, but a raise in the same cycle wins.
      if (link.fp_exc_ack) begin
         fp_req_nxt = 1'b0;
         fp_cnt_nxt = fp_cnt_r + 8'h01;
      end
      if (link.cp2_exc_ack) begin
         cp2_req_nxt = 1'b0;
         cp2_cnt_nxt = cp2_cnt_r + 8'h01;
      end
      if (wr && paddr == ESC_OFF_CTRL) begin
         if (pwdata[ESC_CTRL_FP_BIT]) fp_req_nxt = 1'b1; // RULE_06
         if (pwdata[ESC_CTRL_CP2_BIT]) cp2_req_nxt = 1'b1; // RULE_07
      end
      if (wr && paddr == ESC_OFF_FP_CONTROL_STATUS_REG) fp_control_status_reg_nxt = pwdata[ESC_FP_CONTROL_STATUS_REG_W-1:0]; // RULE_06
      if (wr && paddr == ESC_OFF_INT) begin
         pend_nxt = pwdata[ESC_INT_PEND_LSB +: 8];
         ipl_nxt = pwdata[ESC_INT_IPL_LSB +: 6];
         set_nxt = pwdata[ESC_INT_SET_LSB +: 4]; // RULE_21
      end
      // Read data is loaded in the setup cycle, so the register already holds it through the access phase.
      if (psel && !penable && !pwrite) begin
         case (paddr)
            ESC_OFF_CTRL: rdata_nxt = {30'h0, cp2_req_r, fp_req_r};
            ESC_OFF_FP_CONTROL_STATUS_REG: rdata_nxt = {26'h0, fp_control_status_reg_r};
            ESC_OFF_INT: rdata_nxt = {12'h0, set_r, 2'h0, ipl_r, pend_r};
            ESC_OFF_STATUS: rdata_nxt = {8'h0, cp2_cnt_r, fp_cnt_r, 6'h0, cp2_req_r, fp_req_r};
            default: rdata_nxt = 32'h0;
         endcase
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         fp_req_r <= 1'b0;
         cp2_req_r <= 1'b0;
         fp_control_status_reg_r <= '0;
         pend_r <= 8'h00;
         ipl_r <= 6'h00;
         set_r <= 4'h0;
         fp_cnt_r <= 8'h00;
         cp2_cnt_r <= 8'h00;
         rdata_r <= 32'h0;
      end else begin
         fp_req_r <= fp_req_nxt;
         cp2_req_r <= cp2_req_nxt;
         fp_control_status_reg_r <= fp_control_status_reg_nxt;
         pend_r <= pend_nxt;
         ipl_r <= ipl_nxt;
         set_r <= set_nxt;
         fp_cnt_r <= fp_cnt_nxt;
         cp2_cnt_r <= cp2_cnt_nxt;
         rdata_r <= rdata_nxt;
      end
   end

   assign link.fp_exc_req = fp_req_r;
   assign link.cp2_exc_req = cp2_req_r;
   assign link.int_pending = pend_r;
   assign link.interrupt_priority_level = ipl_r;
   assign link.controller_supplied_set = set_r;
endmodule

// ### esc_link_chk.sv
`timescale 1ns/100ps
module esc_link_chk (
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // Coprocessor request and acknowledge lines
   input wire logic fp_exc_req,
   input wire logic cp2_exc_req,
   input wire logic fp_exc_ack,
   input wire logic cp2_exc_ack
);
   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);

   a_fp_ack_cause: assert property (fp_exc_ack |-> fp_exc_req)
      else $error("fp ack without request");
   a_cp2_ack_cause: assert property (cp2_exc_ack |-> cp2_exc_req)
      else $error("cp2 ack without request");
   a_ack_one_class: assert property (fp_exc_ack |-> !cp2_exc_ack)
      else $error("both classes acknowledged together");
   a_fp_req_hold: assert property (fp_exc_req && !fp_exc_ack |=> fp_exc_req)
      else $error("fp request dropped before ack");
   a_cp2_req_hold: assert property (cp2_exc_req && !cp2_exc_ack |=> cp2_exc_req)
      else $error("cp2 request dropped before ack");
   a_fp_req_drop: assert property (fp_exc_ack |=> !fp_exc_req ##1 !fp_exc_ack)
      else $error("fp request kept after ack");
   a_cp2_req_drop: assert property (cp2_exc_ack |=> !cp2_exc_req && !cp2_exc_ack)
      else $error("cp2 request kept after ack");
   a_fp_ack_soon: assert property ($rose(fp_exc_req) |-> ##[0:3] fp_exc_ack)
      else $error("fp request not served");
   a_cp2_wait_fp: assert property (cp2_exc_req && fp_exc_ack |=> $stable(cp2_exc_req))
      else $error("cp2 request lost behind fp");
endmodule

// ### esc_link_if.sv
`timescale 1ns/100ps
interface esc_link_if;
   logic fp_exc_req;
   logic cp2_exc_req;
   logic fp_exc_ack;
   logic cp2_exc_ack;
   logic [7:0] int_pending;
   logic [5:0] interrupt_priority_level;
   logic [3:0] controller_supplied_set;

   modport dev (
      input fp_exc_req, cp2_exc_req, int_pending, interrupt_priority_level, controller_supplied_set,
      output fp_exc_ack, cp2_exc_ack
   );
   modport far (
      output fp_exc_req, cp2_exc_req, int_pending, interrupt_priority_level, controller_supplied_set,
      input fp_exc_ack, cp2_exc_ack
   );
endinterface

// ### esc_pkg.sv
package esc_pkg;
   // Instruction classes presented by the pipeline.
   typedef enum logic [2:0] {
      ESC_IC_NONE = 3'b000,
      ESC_IC_SYS = 3'b001,
      ESC_IC_FP = 3'b010,
      ESC_IC_CP2 = 3'b011,
      ESC_IC_MEDIA = 3'b100,
      ESC_IC_OTHER = 3'b101
   } esc_iclass_t;

   localparam int ESC_SET_W = 4;
   localparam int ESC_NUM_SETS = 16;
   localparam int ESC_NUM_INT = 8;
   localparam int ESC_IPL_W = 6;
   localparam int ESC_CODE_W = 5;
   localparam int ESC_VEC_W = 12;
   localparam logic [11:0] ESC_VEC_GENERAL = 12'h180;
   localparam logic [11:0] ESC_VEC_INTERRUPT = 12'h200;
   localparam logic [1:0] ESC_UNIT_SYS = 2'h0;
   localparam logic [1:0] ESC_UNIT_FP = 2'h1;
   localparam logic [1:0] ESC_UNIT_CP2 = 2'h2;

   // Default class codes; the real encodings come in as module parameters.
   localparam logic [4:0] ESC_DEF_CODE_INT = 5'h00;
   localparam logic [4:0] ESC_DEF_CODE_CPU = 5'h0b;
   localparam logic [4:0] ESC_DEF_CODE_MEDIA = 5'h16;
   localparam logic [4:0] ESC_DEF_CODE_FP = 5'h0f;
   localparam logic [4:0] ESC_DEF_CODE_CP2 = 5'h12;
   localparam logic [4:0] ESC_DEF_CODE_WATCH = 5'h17;

   // Far-end APB register map.
   localparam logic [7:0] ESC_OFF_CTRL = 8'h00;
   localparam logic [7:0] ESC_OFF_FP_CONTROL_STATUS_REG = 8'h04;
   localparam logic [7:0] ESC_OFF_INT = 8'h08;
   localparam logic [7:0] ESC_OFF_STATUS = 8'h0c;
   localparam int ESC_CTRL_FP_BIT = 0;
   localparam int ESC_CTRL_CP2_BIT = 1;
   localparam int ESC_FP_CONTROL_STATUS_REG_W = 6;
   localparam int ESC_INT_PEND_LSB = 0;
   localparam int ESC_INT_IPL_LSB = 8;
   localparam int ESC_INT_SET_LSB = 16;
   localparam int ESC_STAT_FPCNT_LSB = 8;
   localparam int ESC_STAT_CP2CNT_LSB = 16;
endpackage

// ### exception_shadow_set_control_tb.sv
`timescale 1ns/100ps
module exception_shadow_set_control_tb;
   import esc_pkg::*;
   typedef struct packed {esc_iclass_t c; logic [5:0] lv; logic tk; logic [4:0] code; logic [1:0] unit;} esc_row_t;
   // Level order: debug, kernel, sys, fp, cp2, media usable.
   localparam esc_row_t ROWS [10] = '{
      '{ESC_IC_SYS, 6'h07, 1'h1, ESC_DEF_CODE_CPU, 2'h0}, '{ESC_IC_SYS, 6'h17, 1'h0, 5'h00, 2'h0},
      '{ESC_IC_SYS, 6'h27, 1'h0, 5'h00, 2'h0}, '{ESC_IC_SYS, 6'h0f, 1'h0, 5'h00, 2'h0},
      '{ESC_IC_FP, 6'h1b, 1'h1, ESC_DEF_CODE_CPU, 2'h1}, '{ESC_IC_FP, 6'h07, 1'h0, 5'h00, 2'h0},
      '{ESC_IC_CP2, 6'h1d, 1'h1, ESC_DEF_CODE_CPU, 2'h2}, '{ESC_IC_MEDIA, 6'h1e, 1'h1, ESC_DEF_CODE_MEDIA, 2'h0},
      '{ESC_IC_MEDIA, 6'h1f, 1'h0, 5'h00, 2'h0}, '{ESC_IC_OTHER, 6'h00, 1'h0, 5'h00, 2'h0}};
   localparam logic [9:0] E_IV = 10'h200, E_WM = 10'h100, E_LX = 10'h080, E_IE = 10'h040, E_ER = 10'h020;
   localparam logic [9:0] E_DR = 10'h010, E_SE = 10'h008, E_WC = 10'h004, E_SW = 10'h002, E_MW = 10'h001;
   int err_total = 0;
   int checked = 0;
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr, er;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic [9:0] ev;
   logic instr_valid, watch_match, lower_exc_req, int_enable, exception_return_instr, debug_return_instr;
   logic special_entry, wp_clear, srs_wr, map_wr, read_prev_set_instr, write_prev_set_instr;
   logic debug_mode, kernel_mode, sys_coproc_usable, fp_coproc_usable, coproc2_usable, media_ext_usable;
   logic exception_level_bit, error_level_bit, bootstrap_vector_bit, interrupt_vector_select;
   logic external_int_ctrl_present, vectored_int_supported, exc_taken, watch_pending;
   esc_iclass_t instr_class;
   logic [4:0] lower_exc_code, exc_code;
   logic [7:0] int_mask, pending_interrupt_field;
   logic [3:0] srs_wr_ess, srs_wr_pss, current_set_number, previous_set_number;
   logic [3:0] exception_set_number, highest_set_number, gpr_access_set;
   logic [31:0] map_wr_data, shadow_set_map;
   logic [11:0] exc_vec_offset;
   logic [1:0] coproc_error_unit;
   assign {instr_valid, watch_match, lower_exc_req, int_enable, exception_return_instr} = ev[9:5];
   assign {debug_return_instr, special_entry, wp_clear, srs_wr, map_wr} = ev[4:0];

   esc_link_if lnk ();
   esc_far i_esc_far (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
      .link(lnk));
   esc_dev i_esc_dev (.pclk, .presetn, .instr_valid, .instr_class, .read_prev_set_instr, .write_prev_set_instr,
      .watch_match, .lower_exc_req, .lower_exc_code, .debug_mode, .kernel_mode, .sys_coproc_usable,
      .fp_coproc_usable, .coproc2_usable, .media_ext_usable, .exception_level_bit, .error_level_bit,
      .bootstrap_vector_bit, .int_enable, .int_mask, .interrupt_vector_select, .external_int_ctrl_present,
      .vectored_int_supported, .special_entry, .exception_return_instr, .debug_return_instr, .wp_clear, .srs_wr,
      .srs_wr_ess, .srs_wr_pss, .map_wr, .map_wr_data, .exc_taken, .exc_code, .exc_vec_offset, .coproc_error_unit,
      .watch_pending, .pending_interrupt_field, .current_set_number, .previous_set_number, .exception_set_number,
      .highest_set_number, .gpr_access_set, .shadow_set_map, .link(lnk));
   esc_link_chk i_esc_link_chk (.pclk, .presetn, .fp_exc_req(lnk.fp_exc_req), .cp2_exc_req(lnk.cp2_exc_req),
      .fp_exc_ack(lnk.fp_exc_ack), .cp2_exc_ack(lnk.cp2_exc_ack));

   initial begin
      pclk = 1'h0;
      forever #5 pclk = ~pclk;
   end

   task automatic test_done;
      $display("checks %0d errors %0d", checked, err_total);
      if (err_total == 0 && checked > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask
   task automatic chk_bit(input logic got, input logic exp);
      checked++;
      if (got !== exp) begin
         err_total++;
         $display("[FAIL] %0t flag got %b expected %b", $time, got, exp);
      end
   endtask
   task automatic chk_vec(input logic [31:0] got, input logic [31:0] exp);
      checked++;
      if (got !== exp) begin
         err_total++;
         $display("[FAIL] %0t value got %h expected %h", $time, got, exp);
      end
   endtask
   // Read data stands from the setup edge on, so it is taken at the edge that sees pready high.
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge pclk) begin psel <= 1'h1; penable <= 1'h0; pwrite <= w; paddr <= a; pwdata <= d; end
      @(posedge pclk) penable <= 1'h1;
      @(posedge pclk);
      while (pready !== 1'h1) @(posedge pclk);
      er = pslverr;
      rd = prdata;
      psel <= 1'h0;
      penable <= 1'h0;
   endtask
   // One-cycle pulse of the event lines, outputs checked just after the sampling edge.
   task automatic fire(input logic [9:0] e);
      @(posedge pclk) ev <= e;
      @(posedge pclk) ev <= 10'h000;
      #1;
   endtask

   initial begin
      #50000;
      err_total++;
      test_done;
   end

   initial begin
      {presetn, psel, penable, pwrite, paddr, pwdata, ev, read_prev_set_instr, write_prev_set_instr} = '0;
      {debug_mode, kernel_mode, sys_coproc_usable, fp_coproc_usable, coproc2_usable, media_ext_usable} = '0;
      {exception_level_bit, error_level_bit, bootstrap_vector_bit, interrupt_vector_select} = '0;
      {external_int_ctrl_present, srs_wr_ess, srs_wr_pss, map_wr_data} = '0;
      instr_class = ESC_IC_NONE;
      vectored_int_supported = 1'h1;
      int_mask = 8'hff;
      lower_exc_code = 5'h04;
      repeat (8) @(posedge pclk);
      #1 chk_bit(exc_taken, 1'h0);
      chk_vec(exc_vec_offset, ESC_VEC_GENERAL);
      chk_vec(highest_set_number, ESC_NUM_SETS - 1);
      chk_vec(current_set_number, 4'h0);
      @(posedge pclk) presetn <= 1'h1;
      foreach (ROWS[i]) begin
         @(posedge pclk) begin
            {debug_mode, kernel_mode, sys_coproc_usable, fp_coproc_usable, coproc2_usable, media_ext_usable} <= ROWS[i].lv;
            instr_class <= ROWS[i].c;
         end
         fire(E_IV);
         chk_bit(exc_taken, ROWS[i].tk);
         if (ROWS[i].tk) chk_vec(exc_code, ROWS[i].code);
         if (ROWS[i].tk) chk_vec(exc_vec_offset, ESC_VEC_GENERAL);
         if (ROWS[i].code == ESC_DEF_CODE_CPU) chk_vec(coproc_error_unit, ROWS[i].unit);
      end
      // Watch taken at once, then deferred, then held off in debug, then replayed from pending.
      fire(E_IV | E_WM);
      chk_vec(exc_code, ESC_DEF_CODE_WATCH);
      chk_bit(watch_pending, 1'h0);
      @(posedge pclk) exception_level_bit <= 1'h1;
      fire(E_IV | E_WM | E_LX);
      chk_vec(exc_code, 5'h04);
      chk_bit(watch_pending, 1'h1);
      @(posedge pclk) #1 chk_bit(exc_taken, 1'h0);
      @(posedge pclk) begin exception_level_bit <= 1'h0; debug_mode <= 1'h1; end
      fire(E_WM);
      chk_bit(exc_taken, 1'h0);
      chk_bit(watch_pending, 1'h1);
      @(posedge pclk) debug_mode <= 1'h0;
      @(posedge pclk) #1 chk_bit(exc_taken, 1'h1);
      chk_vec(exc_code, ESC_DEF_CODE_WATCH);
      fire(E_WC);
      @(posedge pclk) #1 chk_bit(exc_taken, 1'h0);
      chk_bit(watch_pending, 1'h0);
      // Coprocessor requests raised through the far end.
      apb(1'h1, ESC_OFF_CTRL, 32'h00000001);
      @(posedge pclk) #1 chk_bit(exc_taken, 1'h1);
      chk_vec(exc_code, ESC_DEF_CODE_FP);
      apb(1'h1, ESC_OFF_CTRL, 32'h00000002);
      @(posedge pclk) #1 chk_vec(exc_code, ESC_DEF_CODE_CP2);
      chk_vec(exc_vec_offset, ESC_VEC_GENERAL);
      apb(1'h1, ESC_OFF_FP_CONTROL_STATUS_REG, 32'h00000015);
      apb(1'h0, ESC_OFF_FP_CONTROL_STATUS_REG, 32'h00000000);
      chk_vec(rd, 32'h00000015);
      apb(1'h0, ESC_OFF_STATUS, 32'h00000000);
      chk_vec(rd & 32'h00ffff03, 32'h00010100);
      apb(1'h0, 8'h10, 32'h00000000);
      chk_bit(er, 1'h1);
      chk_vec(rd, 32'h00000000);
      // Shadow sets on interrupt entry from each source.
      @(posedge pclk) begin srs_wr_ess <= 4'h5; map_wr_data <= 32'h00000700; end
      fire(E_SW | E_MW);
      chk_vec(exception_set_number, 4'h5);
      chk_vec(shadow_set_map, 32'h00000700);
      apb(1'h1, ESC_OFF_INT, 32'h00030004);
      repeat (2) @(posedge pclk);
      fire(E_IE);
      chk_vec(exc_code, ESC_DEF_CODE_INT);
      chk_vec(exc_vec_offset, ESC_VEC_GENERAL);
      chk_vec(pending_interrupt_field, 8'h04);
      chk_vec({current_set_number, previous_set_number}, 8'h50);
      @(posedge pclk) interrupt_vector_select <= 1'h1;
      fire(E_IE);
      chk_vec(exc_vec_offset, ESC_VEC_INTERRUPT);
      chk_vec({current_set_number, previous_set_number}, 8'h75);
      @(posedge pclk) external_int_ctrl_present <= 1'h1;
      fire(E_IE);
      chk_vec({current_set_number, previous_set_number}, 8'h37);
      @(posedge pclk) read_prev_set_instr <= 1'h1;
      #1 chk_vec(gpr_access_set, 4'h7);
      @(posedge pclk) begin read_prev_set_instr <= 1'h0; write_prev_set_instr <= 1'h1; end
      #1 chk_vec(gpr_access_set, 4'h7);
      @(posedge pclk) write_prev_set_instr <= 1'h0;
      #1 chk_vec(gpr_access_set, 4'h3);
      // Entries and returns that must leave the set fields alone, then a plain return that restores the previous set.
      @(posedge pclk) exception_level_bit <= 1'h1;
      fire(E_LX);
      chk_bit(exc_taken, 1'h1);
      chk_vec({current_set_number, previous_set_number}, 8'h37);
      @(posedge pclk) exception_level_bit <= 1'h0;
      fire(E_LX | E_SE);
      chk_bit(exc_taken, 1'h0);
      @(posedge pclk) bootstrap_vector_bit <= 1'h1;
      fire(E_LX);
      fire(E_ER);
      chk_vec({current_set_number, previous_set_number}, 8'h37);
      @(posedge pclk) bootstrap_vector_bit <= 1'h0;
      fire(E_ER | E_DR);
      chk_vec(current_set_number, 4'h3);
      @(posedge pclk) error_level_bit <= 1'h1;
      fire(E_ER);
      chk_vec(current_set_number, 4'h3);
      @(posedge pclk) error_level_bit <= 1'h0;
      fire(E_ER);
      chk_vec(current_set_number, 4'h7);
      // A reset in mid-run must clear the set fields and the map, then the unit works again.
      @(posedge pclk) presetn <= 1'h0;
      #1 chk_vec({current_set_number, previous_set_number, exception_set_number}, 12'h000);
      chk_vec(shadow_set_map, 32'h00000000);
      repeat (2) @(posedge pclk);
      presetn <= 1'h1;
      fire(E_IV | E_WM);
      chk_bit(exc_taken, 1'h1);
      chk_vec(exc_code, ESC_DEF_CODE_WATCH);
      test_done;
   end
endmodule
